//--- hdl/shift_latch_pkg.sv
/*
 * shared constants and types for the two-wire shift/output latch target
 * assumes a single 250 MHz clock domain samples every pin
 */
package shift_latch_pkg;

	// ==========================================================
	// address byte layout
	localparam logic [3:0] GROUP_ID        = 4'hC;
	localparam int         GROUP_MSB       = 7;
	localparam int         GROUP_LSB       = 4;
	localparam int         SELECT_MSB      = 3;
	localparam int         SELECT_LSB      = 1;
	localparam int         RW_BIT          = 0;

	// ==========================================================
	// subaddresses
	localparam logic [7:0] DATA_SHIFT_REGISTER_OFFSET = 8'h11;
	localparam logic [7:0] SUB_TRANSFER    = 8'h22;
	localparam logic [7:0] SUB_WRITE_XFER  = 8'h44;

	// ==========================================================
	// reset values and counts
	localparam logic [7:0] SHIFT_RESET     = 8'h00;
	localparam logic [7:0] OUTPUT_RESET    = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0] LAST_SEND_BIT   = 4'h7;

	// ==========================================================
	// byte position within a transaction
	localparam logic [1:0] BYTE_ADDR       = 2'h0;
	localparam logic [1:0] BYTE_SUB        = 2'h1;
	localparam logic [1:0] BYTE_DATA       = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_RECV   = 5'h02,
		ST_ACK    = 5'h04,
		ST_SEND   = 5'h08,
		ST_IGNORE = 5'h10
	} state_t;

	// every pin sampled from outside the clock domain
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [2:0] select;
	} pins_t;

endpackage

//--- hdl/shift_latch_target.sv
/*
 * two-wire serial target with an 8-bit data shift register feeding an
 * 8-bit output storage register that drives eight low-side switches
 * assumes scl, sda and the select pins are asynchronous to ref_clk and
 * that the serial clock is far slower than ref_clk
 */
// What this block does
// RL1 - address byte must be group 1100, select pins, then read/write bit
// RL2 - subaddress 11H with read returns the data shift register
// RL3 - subaddress 11H with write loads shift register, output unchanged
// RL4 - subaddress 22H write copies shift register into output register
// RL5 - 22H copy happens in subaddress acknowledge; later data byte ignored
// RL6 - 44H write loads data then copies to output in its acknowledge
// RL7 - 44H with read bit set ignores data and transfer
// RL8 - other subaddresses change no register
// RL9 - undefined subaddress: address acked, subaddress and data not acked
// RL10 - write with 11H or 44H acks address, subaddress and data
// RL11 - read and 22H transfer ack only address and subaddress
// RL12 - shift register holds until transfer; output register sets switches
// RL13 - controller sends start, address, subaddress, optional data, stop
// RL14 - start is sda fall with scl high; stop is sda rise with scl high
// RL15 - transaction ends at stop or once the data byte is received
// RL16 - address mismatch: no acknowledge, ignore bus until next start
// RL17 - both registers clear to zero at reset
`timescale 1ns/1ps

module shift_latch_target (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// serial bus, open drain data
	input  wire logic       scl,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOeN,
	// device select pins
	input  wire logic [2:0] selectPins,
	// switch drive, high turns a switch on
	output logic      [7:0] switchOn
);

	// ==========================================================
	// pin synchronisers
	shift_latch_pkg::pins_t pinRaw;
	shift_latch_pkg::pins_t sync1_q, sync1_d;
	shift_latch_pkg::pins_t sync2_q, sync2_d;
	shift_latch_pkg::pins_t sync3_q, sync3_d;
	shift_latch_pkg::pins_t filt_q, filt_d;
	shift_latch_pkg::pins_t prev_q, prev_d;

	assign pinRaw = '{scl: scl, sda: sdaIn, select: selectPins};

	always_comb begin
		sync1_d = pinRaw;
		sync2_d = sync1_q;
		sync3_d = sync2_q;
		// a change counts once stages two and three agree
		filt_d  = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
		prev_d  = filt_q;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync1_q <= '{scl: 1'b1, sda: 1'b1, select: 3'h0};
			sync2_q <= '{scl: 1'b1, sda: 1'b1, select: 3'h0};
			sync3_q <= '{scl: 1'b1, sda: 1'b1, select: 3'h0};
			filt_q  <= '{scl: 1'b1, sda: 1'b1, select: 3'h0};
			prev_q  <= '{scl: 1'b1, sda: 1'b1, select: 3'h0};
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			sync3_q <= sync3_d;
			filt_q  <= filt_d;
			prev_q  <= prev_d;
		end
	end

	// ==========================================================
	// bus events
	logic sclRise, sclFall, startSeen, stopSeen;

	assign sclRise   = filt_q.scl & ~prev_q.scl;
	assign sclFall   = ~filt_q.scl & prev_q.scl;
	assign startSeen = filt_q.scl & prev_q.scl & prev_q.sda & ~filt_q.sda; // RL14
	assign stopSeen  = filt_q.scl & prev_q.scl & ~prev_q.sda & filt_q.sda; // RL14

	// ==========================================================
	// transaction engine
	shift_latch_pkg::state_t state_q, state_d;
	logic [1:0] byteIdx_q, byteIdx_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] rxByte_q, rxByte_d;
	logic [7:0] txByte_q, txByte_d;
	logic [7:0] sub_q, sub_d;
	logic       rw_q, rw_d;
	logic [7:0] dataShift_q, dataShift_d;
	logic [7:0] outStore_q, outStore_d;

	logic       byteDone, addrMatch, subValid, isWrite;

	assign byteDone  = (state_q == shift_latch_pkg::ST_RECV) && sclFall &&
		(bitCnt_q == shift_latch_pkg::BITS_PER_BYTE);
	assign addrMatch = (rxByte_q[shift_latch_pkg::GROUP_MSB:
		shift_latch_pkg::GROUP_LSB] == shift_latch_pkg::GROUP_ID) &&
		(rxByte_q[shift_latch_pkg::SELECT_MSB:shift_latch_pkg::SELECT_LSB]
		== filt_q.select); // RL1
	assign subValid  =
		(rxByte_q == shift_latch_pkg::DATA_SHIFT_REGISTER_OFFSET) ||
		(rxByte_q == shift_latch_pkg::SUB_TRANSFER) ||
		(rxByte_q == shift_latch_pkg::SUB_WRITE_XFER);
	assign isWrite   = ~rw_q;

	always_comb begin
		state_d     = state_q;
		byteIdx_d   = byteIdx_q;
		bitCnt_d    = bitCnt_q;
		rxByte_d    = rxByte_q;
		txByte_d    = txByte_q;
		sub_d       = sub_q;
		rw_d        = rw_q;
		dataShift_d = dataShift_q; // RL12
		outStore_d  = outStore_q; // RL12
		if (startSeen) begin
			state_d   = shift_latch_pkg::ST_RECV;
			byteIdx_d = shift_latch_pkg::BYTE_ADDR;
			bitCnt_d  = 4'h0;
		end else if (stopSeen) begin
			state_d = shift_latch_pkg::ST_IDLE; // RL15
		end else begin
			case (state_q)
				shift_latch_pkg::ST_RECV: begin
					if (sclRise && bitCnt_q != shift_latch_pkg::BITS_PER_BYTE) begin
						// most significant bit arrives first
						rxByte_d = {rxByte_q[6:0], filt_q.sda}; // RL13
						bitCnt_d = bitCnt_q + 4'h1;
					end else if (byteDone) begin
						bitCnt_d = 4'h0;
						state_d  = shift_latch_pkg::ST_IGNORE; // RL7 RL8
						case (byteIdx_q)
							shift_latch_pkg::BYTE_ADDR: begin
								rw_d = rxByte_q[shift_latch_pkg::RW_BIT];
								if (addrMatch) begin
									state_d = shift_latch_pkg::ST_ACK; // RL1
								end
							end
							shift_latch_pkg::BYTE_SUB: begin
								sub_d = rxByte_q;
								if (subValid) begin
									state_d = shift_latch_pkg::ST_ACK; // RL9
									if (isWrite && rxByte_q == shift_latch_pkg::SUB_TRANSFER) begin
										outStore_d = dataShift_q; // RL4 RL5
									end
								end
							end
							shift_latch_pkg::BYTE_DATA: begin
								if (isWrite &&
									sub_q == shift_latch_pkg::DATA_SHIFT_REGISTER_OFFSET) begin
									dataShift_d = rxByte_q; // RL3
									state_d     = shift_latch_pkg::ST_ACK; // RL10
								end else if (isWrite &&
									sub_q == shift_latch_pkg::SUB_WRITE_XFER) begin
									dataShift_d = rxByte_q; // RL6
									outStore_d  = rxByte_q; // RL6
									state_d     = shift_latch_pkg::ST_ACK; // RL10
								end
							end
							default: begin
								state_d = shift_latch_pkg::ST_IGNORE;
							end
						endcase
					end
				end
				shift_latch_pkg::ST_ACK: begin
					if (sclFall) begin
						bitCnt_d  = 4'h0;
						byteIdx_d = byteIdx_q + 2'h1;
						state_d   = shift_latch_pkg::ST_RECV;
						if (byteIdx_q == shift_latch_pkg::BYTE_DATA) begin
							state_d = shift_latch_pkg::ST_IGNORE; // RL15
						end else if (byteIdx_q == shift_latch_pkg::BYTE_SUB &&
							sub_q == shift_latch_pkg::DATA_SHIFT_REGISTER_OFFSET &&
							rw_q) begin
							state_d  = shift_latch_pkg::ST_SEND; // RL2
							txByte_d = dataShift_q; // RL2
						end else if (byteIdx_q == shift_latch_pkg::BYTE_SUB &&
							sub_q == shift_latch_pkg::SUB_TRANSFER) begin
							state_d = shift_latch_pkg::ST_IGNORE; // RL5 RL11
						end
					end
				end
				shift_latch_pkg::ST_SEND: begin
					if (sclFall) begin
						txByte_d = {txByte_q[6:0], 1'b0};
						bitCnt_d = bitCnt_q + 4'h1;
						if (bitCnt_q == shift_latch_pkg::LAST_SEND_BIT) begin
							state_d = shift_latch_pkg::ST_IGNORE; // RL11
						end
					end
				end
				shift_latch_pkg::ST_IDLE, shift_latch_pkg::ST_IGNORE: begin
					state_d = state_q; // RL16
				end
				default: begin
					state_d = shift_latch_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q     <= shift_latch_pkg::ST_IDLE;
			byteIdx_q   <= shift_latch_pkg::BYTE_ADDR;
			bitCnt_q    <= 4'h0;
			rxByte_q    <= 8'h00;
			txByte_q    <= 8'h00;
			sub_q       <= 8'h00;
			rw_q        <= 1'b0;
			dataShift_q <= shift_latch_pkg::SHIFT_RESET; // RL17
			outStore_q  <= shift_latch_pkg::OUTPUT_RESET; // RL17
		end else begin
			state_q     <= state_d;
			byteIdx_q   <= byteIdx_d;
			bitCnt_q    <= bitCnt_d;
			rxByte_q    <= rxByte_d;
			txByte_q    <= txByte_d;
			sub_q       <= sub_d;
			rw_q        <= rw_d;
			dataShift_q <= dataShift_d;
			outStore_q  <= outStore_d;
		end
	end

	// ==========================================================
	// pin drive
	assign sdaOut   = 1'b0;
	assign sdaOeN   = ~((state_q == shift_latch_pkg::ST_ACK) ||
		((state_q == shift_latch_pkg::ST_SEND) && ~txByte_q[7])); // RL10 RL2
	assign switchOn = outStore_q; // RL12

	// ==========================================================
	// checks
	sequence s_addrEnd;
		byteDone && byteIdx_q == shift_latch_pkg::BYTE_ADDR;
	endsequence
	sequence s_subEnd;
		byteDone && byteIdx_q == shift_latch_pkg::BYTE_SUB;
	endsequence
	sequence s_dataEnd;
		byteDone && byteIdx_q == shift_latch_pkg::BYTE_DATA;
	endsequence

	property p_addrAck; // RL1
		@(posedge ref_clk) disable iff (reset)
		s_addrEnd ##0 addrMatch |=> !sdaOeN;
	endproperty
	a_addrAck: assert property (p_addrAck) // RL1
		else $error("matching address not acknowledged");

	property p_addrNack; // RL16
		@(posedge ref_clk) disable iff (reset)
		s_addrEnd ##0 !addrMatch |=>
			sdaOeN && state_q == shift_latch_pkg::ST_IGNORE;
	endproperty
	a_addrNack: assert property (p_addrNack) // RL16
		else $error("mismatched address was acknowledged");

	property p_writeLoad; // RL3
		@(posedge ref_clk) disable iff (reset)
		s_dataEnd ##0 (isWrite &&
			sub_q == shift_latch_pkg::DATA_SHIFT_REGISTER_OFFSET) |=>
			dataShift_q == $past(rxByte_q) && $stable(outStore_q) && !sdaOeN;
	endproperty
	a_writeLoad: assert property (p_writeLoad) // RL3
		else $error("shift register write wrong");

	property p_transfer; // RL5
		@(posedge ref_clk) disable iff (reset)
		s_subEnd ##0 (isWrite && rxByte_q == shift_latch_pkg::SUB_TRANSFER)
			|=> outStore_q == $past(dataShift_q) && !sdaOeN;
	endproperty
	a_transfer: assert property (p_transfer) // RL5
		else $error("transfer command did not copy in acknowledge");

	property p_writeXfer; // RL6
		@(posedge ref_clk) disable iff (reset)
		s_dataEnd ##0 (isWrite && sub_q == shift_latch_pkg::SUB_WRITE_XFER)
			|=> outStore_q == $past(rxByte_q) && dataShift_q == outStore_q;
	endproperty
	a_writeXfer: assert property (p_writeXfer) // RL6
		else $error("write and transfer failed");

	property p_readXferIgnored; // RL7
		@(posedge ref_clk) disable iff (reset)
		s_dataEnd ##0 (rw_q && sub_q == shift_latch_pkg::SUB_WRITE_XFER) |=>
			$stable(outStore_q) && $stable(dataShift_q) && sdaOeN;
	endproperty
	a_readXferIgnored: assert property (p_readXferIgnored) // RL7
		else $error("read with write-transfer subaddress changed state");

	property p_undefSub; // RL9
		@(posedge ref_clk) disable iff (reset)
		s_subEnd ##0 !subValid |=> sdaOeN &&
			state_q == shift_latch_pkg::ST_IGNORE ##1 $stable(outStore_q);
	endproperty
	a_undefSub: assert property (p_undefSub) // RL9
		else $error("undefined subaddress acknowledged");

	property p_sendBit; // RL2
		@(posedge ref_clk) disable iff (reset)
		state_q == shift_latch_pkg::ST_SEND |->
			sdaOeN == dataShift_q[3'h7 - bitCnt_q[2:0]];
	endproperty
	a_sendBit: assert property (p_sendBit) // RL2
		else $error("read data bit not on the line");

	property p_stopEnds; // RL15
		@(posedge ref_clk) disable iff (reset)
		stopSeen && !startSeen |=> state_q == shift_latch_pkg::ST_IDLE && sdaOeN;
	endproperty
	a_stopEnds: assert property (p_stopEnds) // RL15
		else $error("stop did not end the transaction");

	property p_outHold; // RL12
		@(posedge ref_clk) disable iff (reset)
		!byteDone |=> $stable(outStore_q) && $stable(dataShift_q);
	endproperty
	a_outHold: assert property (p_outHold) // RL12
		else $error("registers changed outside a byte end");

	property p_resetClear; // RL17
		@(posedge ref_clk)
		reset |=> switchOn == shift_latch_pkg::OUTPUT_RESET &&
			dataShift_q == shift_latch_pkg::SHIFT_RESET;
	endproperty
	a_resetClear: assert property (p_resetClear) // RL17
		else $error("registers not cleared by reset");

endmodule

//--- sim/bus_controller_model.sv
/*
 * behavioural two-wire bus controller facing the latch target
 * assumes a pull-up on sda, wire level worked out by the bench,
 * scl period of 12 ref_clk cycles (48 ns), scl held high between frames
 */
`timescale 1ns/1ps

module bus_controller_model (
	// clock
	input  wire logic       ref_clk,
	// request from the bench, held until done
	input  wire logic       reqValid,
	input  wire logic [7:0] reqAddr,
	input  wire logic [7:0] reqSub,
	input  wire logic [7:0] reqData,
	input  wire logic       reqWithData,
	// result to the bench
	output logic            done,
	output logic      [2:0] acks,
	output logic      [7:0] rdData,
	// two-wire bus
	output logic            scl,
	output logic            sdaLow,
	input  wire logic       sdaWire
);
	logic bitIn;

	task automatic waitClk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// sda changes 2 clocks into scl low, sampled mid high
	task automatic oneBit(input logic drive, output logic seen);
		sdaLow <= drive;
		waitClk(4);
		scl <= 1'b1;
		waitClk(3);
		seen = sdaWire;
		waitClk(3);
		scl <= 1'b0;
		waitClk(2);
	endtask

	task automatic sendByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			oneBit(~b[i], bitIn);
		end
		oneBit(1'b0, bitIn);
		ack = ~bitIn;
	endtask

	// ==========================================================
	// transaction engine
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		done = 1'b0;
		acks = 3'h0;
		rdData = 8'h00;
		forever begin
			@(posedge ref_clk);
			if (reqValid && !done) begin
				sdaLow <= 1'b1;
				waitClk(6);
				scl <= 1'b0;
				waitClk(2);
				sendByte(reqAddr, acks[2]);
				sendByte(reqSub, acks[1]);
				acks[0] = 1'b0;
				rdData = 8'h00;
				if (reqAddr[0] && !reqWithData) begin
					for (int i = 7; i >= 0; i--) begin
						oneBit(1'b0, bitIn);
						rdData[i] = bitIn;
					end
					oneBit(1'b0, bitIn);
				end else if (reqWithData) begin
					sendByte(reqData, acks[0]);
				end
				sdaLow <= 1'b1;
				waitClk(4);
				scl <= 1'b1;
				waitClk(6);
				sdaLow <= 1'b0;
				waitClk(12);
				done <= 1'b1;
				waitClk(1);
				done <= 1'b0;
			end
		end
	end
endmodule

//--- sim/tb_top.sv
/*
 * self-checking bench for the two-wire shift/output latch target
 * assumes the controller model above and a pulled-up sda wire
 */
`timescale 1ns/1ps

module tb_top;
	typedef struct packed {
		logic [2:0] acks;
		logic [7:0] rd;
		logic [7:0] sw;
	} expect_t;

	logic       ref_clk;
	logic       reset;
	logic       scl;
	logic       sdaLow;
	logic       sdaOut;
	logic       sdaOeN;
	logic       sdaWire;
	logic [2:0] selectPins;
	logic [7:0] switchOn;
	logic       reqValid;
	logic       reqWithData;
	logic       done;
	logic [7:0] reqAddr;
	logic [7:0] reqSub;
	logic [7:0] reqData;
	logic [7:0] rdData;
	logic [2:0] acks;
	logic [7:0] lfsr;
	logic [7:0] shiftModel;
	logic [7:0] outModel;
	logic [7:0] badSub [4];
	expect_t    expQ [$];
	int         fails;
	int         compares;

	assign sdaWire = !sdaLow && (sdaOeN || sdaOut);

	shift_latch_target shift_latch_target_inst (
		.ref_clk(ref_clk), .reset(reset), .scl(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN), .selectPins(selectPins),
		.switchOn(switchOn));

	bus_controller_model bus_controller_model_inst (
		.ref_clk(ref_clk), .reqValid(reqValid), .reqAddr(reqAddr),
		.reqSub(reqSub), .reqData(reqData), .reqWithData(reqWithData),
		.done(done), .acks(acks), .rdData(rdData), .scl(scl),
		.sdaLow(sdaLow), .sdaWire(sdaWire));

	// ==========================================================
	// helpers
	function automatic logic [7:0] lfsrNext(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	function automatic logic [7:0] adr(input logic rw);
		return {4'hC, selectPins, rw};
	endfunction

	task automatic conclude();
		if (expQ.size() != 0) begin
			fails++;
			$display("ERROR expQ expected %0d seen %0d", 0, expQ.size());
		end
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic compareAck(input logic [2:0] exp, input logic [2:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR acks expected %b seen %b", exp, got);
		end
	endtask

	task automatic compareByte(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic [7:0] s,
			input logic [7:0] d, input logic w, input logic [2:0] ea,
			input logic [7:0] er);
		int n;
		expQ.push_back('{ea, er, outModel});
		reqAddr <= a;
		reqSub <= s;
		reqData <= d;
		reqWithData <= w;
		reqValid <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!done && n < 2000);
		if (!done) begin
			fails++;
			conclude();
		end
		reqValid <= 1'b0;
		@(posedge ref_clk);
	endtask

	// ==========================================================
	// clock, monitor and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		expect_t e;
		forever begin
			@(posedge ref_clk);
			if (done && expQ.size() == 0) begin
				fails++;
				$display("ERROR expQ expected %0d seen %0d", 1, 0);
			end else if (done) begin
				e = expQ.pop_front();
				compareAck(e.acks, acks);
				compareByte("rdData", e.rd, rdData);
				compareByte("switchOn", e.sw, switchOn);
			end
		end
	end

	initial begin
		reset = 1'b1;
		reqValid = 1'b0;
		reqWithData = 1'b0;
		reqAddr = 8'h00;
		reqSub = 8'h00;
		reqData = 8'h00;
		selectPins = 3'h5;
		lfsr = 8'h07;
		shiftModel = 8'h00;
		outModel = 8'h00;
		fails = 0;
		compares = 0;
		badSub = '{8'h00, 8'h33, 8'h45, 8'hFF};
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		compareByte("switchOn", 8'h00, switchOn);
		xfer(adr(1), 8'h11, 8'h00, 0, 3'b110, 8'h00);
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsrNext(lfsr);
			selectPins <= lfsr[2:0];
			repeat (8) @(posedge ref_clk);
			shiftModel = lfsr;
			xfer(adr(0), 8'h11, lfsr, 1, 3'b111, 8'h00);
			xfer(adr(1), 8'h44, ~lfsr, 1, 3'b110, 8'h00);
			xfer(adr(k[0]), badSub[k], ~lfsr, 1, 3'b100, 8'h00);
			xfer({4'h9, selectPins, 1'b0}, 8'h44, ~lfsr, 1, 3'b000, 8'h00);
			xfer(adr(0) ^ 8'h02, 8'h44, ~lfsr, 1, 3'b000, 8'h00);
			xfer(adr(1), 8'h11, 8'h00, 0, 3'b110, shiftModel);
			xfer(adr(1), 8'h22, ~lfsr, 1, 3'b110, 8'h00);
			outModel = shiftModel;
			xfer(adr(0), 8'h22, ~lfsr, 1, 3'b110, 8'h00);
			xfer(adr(1), 8'h11, 8'h00, 0, 3'b110, shiftModel);
			lfsr = lfsrNext(lfsr);
			shiftModel = lfsr;
			outModel = lfsr;
			xfer(adr(0), 8'h44, lfsr, 1, 3'b111, 8'h00);
		end
		xfer(adr(1), 8'h11, 8'h00, 0, 3'b110, shiftModel);
		reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		shiftModel = 8'h00;
		outModel = 8'h00;
		compareByte("switchOn", outModel, switchOn);
		xfer(adr(1), 8'h11, 8'h00, 0, 3'b110, shiftModel);
		conclude();
	end
endmodule
